// ---- bench/omc_regs_assertions.sv ----
// Port checks for the output mixer control bank.
// Assumes it is bound into omc_regs and sees only the ports of that module.
`timescale 1ns/10ps
`include "omc_map.svh"

module omc_regs_chk #(
  parameter int ADDR_W = 8                        // Address width.
) (
  input wire logic                     clk_i,       // Clock.
  input wire logic                     arst_n_i,    // Reset, active low.
  input wire logic [ADDR_W-1:0]        addr_i,      // Address.
  input wire logic [8:0]               wdata_i,     // Write data.
  input wire logic                     wr_i,        // Write strobe.
  input wire logic                     rd_i,        // Read strobe.
  input wire logic [8:0]               rdata_o,     // Read data.
  input wire logic                     rvalid_o,    // Read marker.
  input wire omc_pkg::omc_mix_gain_s   rphones_o,   // Right phones controls.
  input wire omc_pkg::omc_spk_src_s    lspk_src_o,  // Left speaker sources.
  input wire omc_pkg::omc_spk_src_s    rspk_src_o,  // Right speaker sources.
  input wire omc_pkg::omc_mix_gain_s   lspk_gain_o, // Left speaker gains.
  input wire omc_pkg::omc_mix_gain_s   rspk_gain_o, // Right speaker gains.
  input wire omc_pkg::omc_dac_atten_s  dac_atten_o  // Converter feed attenuation.
);
  logic [8:0] wd_q;

  // Keeps the last write data so field slices can be compared a cycle later.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wd_q <= 9'h000;
    end else begin
      wd_q <= wdata_i;
    end
  end

  // --------------------------------------------------------------------------
  // Field updates and read-back
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_rphones_write:
    assert property (wr_i && addr_i == `OMC_RPHONES_OFS |=> rphones_o == wd_q)
    else $error("right phones controls do not follow the write");
  a_lsrc_write:
    assert property (wr_i && addr_i == `OMC_LSPK_SRC_OFS |=> lspk_src_o == {wd_q[7], wd_q[5:0]})
    else $error("left speaker sources do not follow the write");
  a_rsrc_write:
    assert property (wr_i && addr_i == `OMC_RSPK_SRC_OFS |=> rspk_src_o == {wd_q[7], wd_q[5:0]})
    else $error("right speaker sources do not follow the write");
  a_lgain_write:
    assert property (wr_i && addr_i == `OMC_LSPK_GAIN_OFS |=> lspk_gain_o == wd_q)
    else $error("left speaker gains do not follow the write");
  a_rgain_write:
    assert property (wr_i && addr_i == `OMC_RSPK_GAIN_OFS |=> rspk_gain_o == wd_q)
    else $error("right speaker gains do not follow the write");
  a_dac_write:
    assert property (wr_i && addr_i == `OMC_DAC_ATTEN_OFS |=> dac_atten_o == {wd_q[7:4], wd_q[1:0]})
    else $error("converter attenuation does not follow the write");
  a_lgain_hold:
    assert property (!(wr_i && addr_i == `OMC_LSPK_GAIN_OFS) |=> $stable(lspk_gain_o))
    else $error("left speaker gains changed without a write");
  a_rphones_read:
    assert property (rd_i && addr_i == `OMC_RPHONES_OFS |=> rvalid_o && rdata_o == $past(rphones_o))
    else $error("right phones read-back differs from the controls");
  a_src_unused_zero:
    assert property (rd_i && (addr_i == `OMC_LSPK_SRC_OFS || addr_i == `OMC_RSPK_SRC_OFS)
                     |=> rdata_o[8] == 1'b0 && rdata_o[6] == 1'b0)
    else $error("unassigned source bits read nonzero");
  a_dac_unused_zero:
    assert property (rd_i && addr_i == `OMC_DAC_ATTEN_OFS |=> rdata_o[8] == 1'b0 && rdata_o[3:2] == 2'b00)
    else $error("unassigned attenuation bits read nonzero");
  a_idle_read_zero:
    assert property (!rd_i |=> rdata_o == 9'h000 && !rvalid_o)
    else $error("read data present without a read strobe");

  c_rphones_write: cover property (wr_i && addr_i == `OMC_RPHONES_OFS);
  c_unmapped_read: cover property (rd_i && addr_i == 8'h68);
  c_dac_read: cover property (rd_i && addr_i == `OMC_DAC_ATTEN_OFS);
endmodule

bind omc_regs omc_regs_chk #(.ADDR_W(ADDR_W)) u_omc_regs_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rphones_o(rphones_o), .lspk_src_o(lspk_src_o),
  .rspk_src_o(rspk_src_o), .lspk_gain_o(lspk_gain_o), .rspk_gain_o(rspk_gain_o), .dac_atten_o(dac_atten_o));

// ---- bench/testbench.sv ----
// Self-checking bench for the output mixer control bank.
// Assumes omc_pkg is compiled first and omc_map.svh is on the include path.
`timescale 1ns/10ps
`include "omc_map.svh"

module testbench;
  logic                     clk_i;
  logic                     arst_n_i;
  logic [7:0]               addr_i;
  logic [8:0]               wdata_i;
  logic                     wr_i;
  logic                     rd_i;
  logic [8:0]               rdata_o;
  logic                     rvalid_o;
  omc_pkg::omc_mix_gain_s   rphones_o;
  omc_pkg::omc_spk_src_s    lspk_src_o;
  omc_pkg::omc_spk_src_s    rspk_src_o;
  omc_pkg::omc_mix_gain_s   lspk_gain_o;
  omc_pkg::omc_mix_gain_s   rspk_gain_o;
  omc_pkg::omc_dac_atten_s  dac_atten_o;
  int                       fails;
  int                       n_checks;
  int                       cycles;
  logic [7:0]               ofs [6];
  logic [8:0]               rst_val [6];
  logic [8:0]               msk [6];
  logic [8:0]               exp_reg [6];

  omc_regs #(.ADDR_W(8)) uut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rphones_o(rphones_o), .lspk_src_o(lspk_src_o),
    .rspk_src_o(rspk_src_o), .lspk_gain_o(lspk_gain_o), .rspk_gain_o(rspk_gain_o), .dac_atten_o(dac_atten_o));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Rebuilds a register image from the control outputs of register i.
  function automatic logic [8:0] out_of(input int i);
    case (i)
      0: out_of = rphones_o;
      1: out_of = {1'b0, lspk_src_o.path_sel, 1'b0, lspk_src_o[5:0]};
      2: out_of = {1'b0, rspk_src_o.path_sel, 1'b0, rspk_src_o[5:0]};
      3: out_of = lspk_gain_o;
      4: out_of = rspk_gain_o;
      default: out_of = {1'b0, dac_atten_o[5:2], 2'b00, dac_atten_o[1:0]};
    endcase
  endfunction

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One write cycle; the bench image keeps only the assigned bits.
  task automatic wr_reg(input logic [7:0] a, input logic [8:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (ofs[i] == a) begin
        exp_reg[i] = d & msk[i];
      end
    end
    #1;
  endtask

  // One read cycle; data and marker are judged in the cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [8:0] exp, input string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk({8'h00, rvalid_o}, 9'h001, "read marker");
    chk(rdata_o, exp, what);
  endtask

  task automatic chk_all(input string what);
    for (int i = 0; i < 6; i++) begin
      rd_chk(ofs[i], exp_reg[i], what);
      chk(out_of(i), exp_reg[i], what);
    end
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_values();
    exp_reg = rst_val;
    chk_all("reset value");
    $display("Test reset values done");
  endtask

  task automatic t_write_read();
    logic [8:0] pat [4];
    logic [8:0] d;
    pat = '{9'h1ff, 9'h000, 9'h155, 9'h0aa};
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 6; i++) begin
        d = (i == 5) ? (pat[p] | 9'h003) : pat[p];
        wr_reg(ofs[i], d);
        chk(out_of(i), d & msk[i], "control outputs");
        rd_chk(ofs[i], d & msk[i], "read back");
      end
    end
    $display("Test write and read done");
  endtask

  task automatic t_gain_codes();
    for (int c = 0; c < 8; c++) begin
      wr_reg(`OMC_RPHONES_OFS, {3'b000, 3'(c), 3'(7 - c)});
      chk({6'h00, rphones_o.aux_left_gain}, {6'h00, 3'(c)}, "left aux gain");
      chk({6'h00, rphones_o.aux_right_gain}, {6'h00, 3'(7 - c)}, "right aux gain");
      wr_reg(`OMC_LSPK_GAIN_OFS, {3'b010, 3'(7 - c), 3'(c)});
      rd_chk(`OMC_LSPK_GAIN_OFS, {3'b010, 3'(7 - c), 3'(c)}, "left speaker gains");
      wr_reg(`OMC_RSPK_GAIN_OFS, {3'b101, 3'(c), 3'(7 - c)});
      rd_chk(`OMC_RSPK_GAIN_OFS, {3'b101, 3'(c), 3'(7 - c)}, "right speaker gains");
    end
    $display("Test gain codes done");
  endtask

  task automatic t_unmapped();
    wr_reg(8'h68, 9'h1ff);
    wr_reg(8'h6e, 9'h1ff);
    rd_chk(8'h68, 9'h000, "unmapped read");
    rd_chk(8'h00, 9'h000, "unmapped read");
    chk_all("unmapped write side effect");
    $display("Test unmapped addresses done");
  endtask

  task automatic t_mid_reset();
    wr_reg(`OMC_RSPK_GAIN_OFS, 9'h000);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    #1;
    for (int i = 0; i < 6; i++) begin
      chk(out_of(i), rst_val[i], "output in reset");
    end
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    exp_reg = rst_val;
    chk_all("after second reset");
    $display("Test mid-run reset done");
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Clock, timeout and main sequence
  // --------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Cuts a hung run short well beyond the few hundred cycles the tests need.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      summarize();
    end
  end

  initial begin
    arst_n_i = 1'b0;
    addr_i   = 8'h00;
    wdata_i  = 9'h000;
    wr_i     = 1'b0;
    rd_i     = 1'b0;
    fails    = 0;
    n_checks = 0;
    cycles   = 0;
    ofs      = '{`OMC_RPHONES_OFS, `OMC_LSPK_SRC_OFS, `OMC_RSPK_SRC_OFS,
                 `OMC_LSPK_GAIN_OFS, `OMC_RSPK_GAIN_OFS, `OMC_DAC_ATTEN_OFS};
    rst_val  = '{9'h13f, 9'h000, 9'h000, 9'h13f, 9'h13f, 9'h003};
    msk      = '{9'h1ff, 9'h0bf, 9'h0bf, 9'h1ff, 9'h1ff, 9'h0f3};
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset_values();
    t_write_read();
    t_gain_codes();
    t_unmapped();
    t_mid_reset();
    summarize();
  end
endmodule

// ---- rtl/omc_map.svh ----
// Register offsets, field positions and reset values of the output mixer control bank.
// Assumes an 8-bit register address and 9-bit register data on the control port.
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OMC_RPHONES_OFS   8'h67
`define OMC_LSPK_SRC_OFS  8'h69
`define OMC_RSPK_SRC_OFS  8'h6a
`define OMC_LSPK_GAIN_OFS 8'h6b
`define OMC_RSPK_GAIN_OFS 8'h6c
`define OMC_DAC_ATTEN_OFS 8'h6d

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OMC_SILENCE_BIT     8
`define OMC_LINMIX_ATT_BIT  7
`define OMC_RINMIX_ATT_BIT  6
`define OMC_AUXL_GAIN_MSB   5
`define OMC_AUXL_GAIN_LSB   3
`define OMC_AUXR_GAIN_MSB   2
`define OMC_AUXR_GAIN_LSB   0
`define OMC_PATH_SEL_BIT    7
`define OMC_LDAC_EN_BIT     5
`define OMC_RDAC_EN_BIT     4
`define OMC_LINMIX_EN_BIT   3
`define OMC_RINMIX_EN_BIT   2
`define OMC_AUXL_EN_BIT     1
`define OMC_AUXR_EN_BIT     0
`define OMC_LDAC_L_ATT_BIT  7
`define OMC_RDAC_L_ATT_BIT  6
`define OMC_LDAC_R_ATT_BIT  5
`define OMC_RDAC_R_ATT_BIT  4
`define OMC_RSVD_MSB        1
`define OMC_RSVD_LSB        0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OMC_SILENCE_RST   1'h1
`define OMC_ATT_RST       1'h0
`define OMC_GAIN_RST      3'h7
`define OMC_EN_RST        1'h0
`define OMC_PATH_SEL_RST  1'h0
`define OMC_RSVD_RST      2'h3

`endif

// ---- rtl/omc_pkg.sv ----
// Types shared by the output mixer control bank and its users.
// Assumes the offsets and field positions of omc_map.svh.
package omc_pkg;

  // --------------------------------------------------------------------------
  // Auxiliary input gain codes, 3 dB per step
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OMC_GAIN_M15DB = 3'b000,
    OMC_GAIN_M12DB = 3'b001,
    OMC_GAIN_M9DB  = 3'b010,
    OMC_GAIN_M6DB  = 3'b011,
    OMC_GAIN_M3DB  = 3'b100,
    OMC_GAIN_0DB   = 3'b101,
    OMC_GAIN_P3DB  = 3'b110,
    OMC_GAIN_P6DB  = 3'b111
  } omc_gain_e;

  // --------------------------------------------------------------------------
  // Mixer control bundles
  // --------------------------------------------------------------------------
  // Mute, input-mixer attenuation and auxiliary gains of one mixer.
  typedef struct packed {
    logic      sum_silence;
    logic      linmix_atten;
    logic      rinmix_atten;
    omc_gain_e aux_left_gain;
    omc_gain_e aux_right_gain;
  } omc_mix_gain_s;

  // Path select and source enables of one speaker mixer.
  typedef struct packed {
    logic path_sel;
    logic ldac_en;
    logic rdac_en;
    logic linmix_en;
    logic rinmix_en;
    logic aux_left_en;
    logic aux_right_en;
  } omc_spk_src_s;

  // Converter feed attenuation into both speaker mixers.
  typedef struct packed {
    logic       ldac_to_lspeaker_atten;
    logic       rdac_to_lspeaker_atten;
    logic       ldac_to_rspeaker_atten;
    logic       rdac_to_rspeaker_atten;
    logic [1:0] reserved;
  } omc_dac_atten_s;

endpackage

// ---- rtl/omc_regs.sv ----
// Output mixer control registers: right headphone mixer and both speaker mixers.
// Assumes a control port master that issues one-cycle read and write strobes.
// Assumes read and write strobes never come together.
// The analogue mixers take the outputs as levels.
//
// Added by the designer: the plain strobed port.

`timescale 1ns/10ps
`include "omc_map.svh"

module omc_regs #(
  parameter int ADDR_W = 8                            // Register address width.
) (
  input  wire logic                   clk_i,          // Register clock, 50 MHz.
  input  wire logic                   arst_n_i,       // Asynchronous reset, active low.
  input  wire logic [ADDR_W-1:0]      addr_i,         // Register address.
  input  wire logic [8:0]             wdata_i,        // Write data.
  input  wire logic                   wr_i,           // Write strobe.
  input  wire logic                   rd_i,           // Read strobe.
  output logic [8:0]                  rdata_o,        // Read data, one cycle after rd_i.
  output logic                        rvalid_o,       // Marks the read data cycle.
  output omc_pkg::omc_mix_gain_s      rphones_o,      // Right headphone mixer controls.
  output omc_pkg::omc_spk_src_s       lspk_src_o,     // Left speaker path and sources.
  output omc_pkg::omc_spk_src_s       rspk_src_o,     // Right speaker path and sources.
  output omc_pkg::omc_mix_gain_s      lspk_gain_o,    // Left speaker mute and gains.
  output omc_pkg::omc_mix_gain_s      rspk_gain_o,    // Right speaker mute and gains.
  output omc_pkg::omc_dac_atten_s     dac_atten_o     // Converter feed attenuation.
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  logic                wr_rphones;
  logic                wr_dac_atten;
  logic [1:0]          wr_spk_src;
  logic [1:0]          wr_spk_gain;
  logic [ADDR_W-1:0]   spk_src_ofs  [2];
  logic [ADDR_W-1:0]   spk_gain_ofs [2];

  // Each access covers one whole 9-bit register.
  // An unmatched address raises no enable at all.

  // Per-channel offsets, index 0 is the left speaker mixer.
  assign spk_src_ofs[0]  = ADDR_W'(`OMC_LSPK_SRC_OFS);
  assign spk_src_ofs[1]  = ADDR_W'(`OMC_RSPK_SRC_OFS);
  assign spk_gain_ofs[0] = ADDR_W'(`OMC_LSPK_GAIN_OFS);
  assign spk_gain_ofs[1] = ADDR_W'(`OMC_RSPK_GAIN_OFS);

  // The speaker enables come from the generate pass.

  // Write enables for the two single registers.
  assign wr_rphones   = wr_i && (addr_i == ADDR_W'(`OMC_RPHONES_OFS));
  assign wr_dac_atten = wr_i && (addr_i == ADDR_W'(`OMC_DAC_ATTEN_OFS));

  // --------------------------------------------------------------------------
  // Right headphone mixer register
  // --------------------------------------------------------------------------
  // Reset leaves this mixer muted, both input feeds
  // at 0dB and both aux gains at the top code.

  logic       rphones_silence;
  logic       rphones_linmix_att;
  logic       rphones_rinmix_att;
  logic [2:0] rphones_auxl_gain;
  logic [2:0] rphones_auxr_gain;

  // One process per field, the two attenuation selects sharing one, keeps each concern apart.

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rphones_silence <= `OMC_SILENCE_RST;
    end else if (wr_rphones) begin
      rphones_silence <= wdata_i[`OMC_SILENCE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rphones_linmix_att <= `OMC_ATT_RST;
      rphones_rinmix_att <= `OMC_ATT_RST;
    end else if (wr_rphones) begin
      rphones_linmix_att <= wdata_i[`OMC_LINMIX_ATT_BIT];
      rphones_rinmix_att <= wdata_i[`OMC_RINMIX_ATT_BIT];
    end
  end

  // Gain codes are kept raw; the mixer maps the steps.

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rphones_auxl_gain <= `OMC_GAIN_RST;
    end else if (wr_rphones) begin
      rphones_auxl_gain <= wdata_i[`OMC_AUXL_GAIN_MSB:`OMC_AUXL_GAIN_LSB];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rphones_auxr_gain <= `OMC_GAIN_RST;
    end else if (wr_rphones) begin
      rphones_auxr_gain <= wdata_i[`OMC_AUXR_GAIN_MSB:`OMC_AUXR_GAIN_LSB];
    end
  end

  // --------------------------------------------------------------------------
  // Speaker mixer registers, one generate pass per channel
  // --------------------------------------------------------------------------
  // Both speaker mixers share one layout, so one pass
  // per channel builds both; index 0 is the left one.
  // Source word: path select and six enables.
  // Gain word: mute, two selects, two aux gains.

  logic [8:0] spk_src_word  [2];
  logic [8:0] spk_gain_word [2];

  for (genvar ch = 0; ch < 2; ch++) begin : g_spk
    logic       path_sel;
    logic [5:0] src_en;
    logic       silence;
    logic       linmix_att;
    logic       rinmix_att;
    logic [2:0] auxl_gain;
    logic [2:0] auxr_gain;

    // Channel write enables.
    assign wr_spk_src[ch]  = wr_i && (addr_i == spk_src_ofs[ch]);
    assign wr_spk_gain[ch] = wr_i && (addr_i == spk_gain_ofs[ch]);

    // Low feeds the converter straight to the speaker
    // stage, high feeds the speaker mixer output.

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        path_sel <= `OMC_PATH_SEL_RST;
      end else if (wr_spk_src[ch]) begin
        path_sel <= wdata_i[`OMC_PATH_SEL_BIT];
      end
    end

    // Enable order from bit 5: left and right
    // converter, input mixer, then aux input.

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        src_en <= {6{`OMC_EN_RST}};
      end else if (wr_spk_src[ch]) begin
        src_en <= wdata_i[`OMC_LDAC_EN_BIT:`OMC_AUXR_EN_BIT];
      end
    end

    // Muted from reset, so no audio passes before
    // software sets up sources and gains.

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        silence <= `OMC_SILENCE_RST;
      end else if (wr_spk_gain[ch]) begin
        silence <= wdata_i[`OMC_SILENCE_BIT];
      end
    end

    // Each select drops its feed by 6dB when set.

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        linmix_att <= `OMC_ATT_RST;
        rinmix_att <= `OMC_ATT_RST;
      end else if (wr_spk_gain[ch]) begin
        linmix_att <= wdata_i[`OMC_LINMIX_ATT_BIT];
        rinmix_att <= wdata_i[`OMC_RINMIX_ATT_BIT];
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        auxl_gain <= `OMC_GAIN_RST;
        auxr_gain <= `OMC_GAIN_RST;
      end else if (wr_spk_gain[ch]) begin
        auxl_gain <= wdata_i[`OMC_AUXL_GAIN_MSB:`OMC_AUXL_GAIN_LSB];
        auxr_gain <= wdata_i[`OMC_AUXR_GAIN_MSB:`OMC_AUXR_GAIN_LSB];
      end
    end

    // Bits 8 and 6 of the source word carry no field
    // and are tied low, so no write can set them.

    assign spk_src_word[ch]  = {1'b0, path_sel, 1'b0, src_en};
    assign spk_gain_word[ch] = {silence, linmix_att, rinmix_att, auxl_gain, auxr_gain};
  end

  // --------------------------------------------------------------------------
  // Converter feed attenuation register
  // --------------------------------------------------------------------------
  // Bits 7 to 4 pick -6dB per converter feed, left
  // to left first and right to right last. Bits 8, 3
  // and 2 carry no field; bits 1 and 0 are reserved.

  logic [3:0] dac_att;
  logic [1:0] dac_rsvd;

  // Only a write to this offset moves the selects.

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dac_att <= {4{`OMC_ATT_RST}};
    end else if (wr_dac_atten) begin
      dac_att <= wdata_i[`OMC_LDAC_L_ATT_BIT:`OMC_RDAC_R_ATT_BIT];
    end
  end

  // Hardware does not force the pair to one, so a
  // driver that writes other values sees its fault.

  // Reserved pair is stored as written so a read shows what software left there.
  // reserved pair kept.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dac_rsvd <= `OMC_RSVD_RST;
    end else if (wr_dac_atten) begin
      dac_rsvd <= wdata_i[`OMC_RSVD_MSB:`OMC_RSVD_LSB];
    end
  end

  // --------------------------------------------------------------------------
  // Read back
  // --------------------------------------------------------------------------
  // The word is picked from the address beside the
  // strobe and registered; the data stand in the
  // cycle after the strobe and are zero elsewhere,
  // so a stale word is never taken for an answer.

  logic [8:0] rphones_word;
  logic [8:0] dac_atten_word;
  logic [8:0] next_rdata;

  // Assembled words, unassigned positions tied low.
  assign rphones_word = {rphones_silence, rphones_linmix_att, rphones_rinmix_att,
                         rphones_auxl_gain, rphones_auxr_gain};
  assign dac_atten_word = {1'b0, dac_att, 2'h0, dac_rsvd};

  // A read right after a write to the same register
  // sees the new value; the write lands on its edge.

  // Read multiplexer; an unmapped address answers zero.
  always_comb begin
    next_rdata = 9'h000;
    case (addr_i)
      ADDR_W'(`OMC_RPHONES_OFS): begin
        next_rdata = rphones_word;
      end
      ADDR_W'(`OMC_LSPK_SRC_OFS): begin
        next_rdata = spk_src_word[0];
      end
      ADDR_W'(`OMC_RSPK_SRC_OFS): begin
        next_rdata = spk_src_word[1];
      end
      ADDR_W'(`OMC_LSPK_GAIN_OFS): begin
        next_rdata = spk_gain_word[0];
      end
      ADDR_W'(`OMC_RSPK_GAIN_OFS): begin
        next_rdata = spk_gain_word[1];
      end
      ADDR_W'(`OMC_DAC_ATTEN_OFS): begin
        next_rdata = dac_atten_word;
      end
      default: begin
        next_rdata = 9'h000;
      end
    endcase
  end

  // The marker tells a zero answer from no answer.

  // Read data stand for the one cycle after the strobe and are zero otherwise.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o  <= 9'h000;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o  <= rd_i ? next_rdata : 9'h000;
      rvalid_o <= rd_i;
    end
  end

  // --------------------------------------------------------------------------
  // Control outputs toward the analogue mixers
  // --------------------------------------------------------------------------
  // Levels straight from the register flops; they
  // change only on a write to their register or on
  // reset. High means muted, -6dB, enabled or mixer.
  // Gain codes run from -15dB at the lowest code in
  // 3dB steps to +6dB and leave as the package enum.

  // Right headphone mixer bundle.
  assign rphones_o.sum_silence    = rphones_silence;
  assign rphones_o.linmix_atten   = rphones_linmix_att;
  assign rphones_o.rinmix_atten   = rphones_rinmix_att;
  assign rphones_o.aux_left_gain  = omc_pkg::omc_gain_e'(rphones_auxl_gain);
  assign rphones_o.aux_right_gain = omc_pkg::omc_gain_e'(rphones_auxr_gain);

  // Enables are taken by field position, so the
  // struct order follows the register layout.

  // Left speaker path and source bundle.
  assign lspk_src_o.path_sel     = g_spk[0].path_sel;
  assign lspk_src_o.ldac_en      = g_spk[0].src_en[`OMC_LDAC_EN_BIT];
  assign lspk_src_o.rdac_en      = g_spk[0].src_en[`OMC_RDAC_EN_BIT];
  assign lspk_src_o.linmix_en    = g_spk[0].src_en[`OMC_LINMIX_EN_BIT];
  assign lspk_src_o.rinmix_en    = g_spk[0].src_en[`OMC_RINMIX_EN_BIT];
  assign lspk_src_o.aux_left_en  = g_spk[0].src_en[`OMC_AUXL_EN_BIT];
  assign lspk_src_o.aux_right_en = g_spk[0].src_en[`OMC_AUXR_EN_BIT];

  // Right speaker path and source bundle.
  assign rspk_src_o.path_sel     = g_spk[1].path_sel;
  assign rspk_src_o.ldac_en      = g_spk[1].src_en[`OMC_LDAC_EN_BIT];
  assign rspk_src_o.rdac_en      = g_spk[1].src_en[`OMC_RDAC_EN_BIT];
  assign rspk_src_o.linmix_en    = g_spk[1].src_en[`OMC_LINMIX_EN_BIT];
  assign rspk_src_o.rinmix_en    = g_spk[1].src_en[`OMC_RINMIX_EN_BIT];
  assign rspk_src_o.aux_left_en  = g_spk[1].src_en[`OMC_AUXL_EN_BIT];
  assign rspk_src_o.aux_right_en = g_spk[1].src_en[`OMC_AUXR_EN_BIT];

  // Gain bundles map the gain word one to one.

  // Left speaker mute and gain bundle.
  assign lspk_gain_o.sum_silence    = g_spk[0].silence;
  assign lspk_gain_o.linmix_atten   = g_spk[0].linmix_att;
  assign lspk_gain_o.rinmix_atten   = g_spk[0].rinmix_att;
  assign lspk_gain_o.aux_left_gain  = omc_pkg::omc_gain_e'(g_spk[0].auxl_gain);
  assign lspk_gain_o.aux_right_gain = omc_pkg::omc_gain_e'(g_spk[0].auxr_gain);

  // Right speaker mute and gain bundle.
  assign rspk_gain_o.sum_silence    = g_spk[1].silence;
  assign rspk_gain_o.linmix_atten   = g_spk[1].linmix_att;
  assign rspk_gain_o.rinmix_atten   = g_spk[1].rinmix_att;
  assign rspk_gain_o.aux_left_gain  = omc_pkg::omc_gain_e'(g_spk[1].auxl_gain);
  assign rspk_gain_o.aux_right_gain = omc_pkg::omc_gain_e'(g_spk[1].auxr_gain);

  // The reserved pair leaves too, for visibility.

  // Converter feed attenuation bundle, bit 7 first.
  assign dac_atten_o.ldac_to_lspeaker_atten = dac_att[3];
  assign dac_atten_o.rdac_to_lspeaker_atten = dac_att[2];
  assign dac_atten_o.ldac_to_rspeaker_atten = dac_att[1];
  assign dac_atten_o.rdac_to_rspeaker_atten = dac_att[0];
  assign dac_atten_o.reserved               = dac_rsvd;

endmodule
